// ===== verilog/dpl_host.sv
`timescale 1ns/1ps
`include "dpl_map.svh"
// controller end: AXI4-Lite registers drive the task-file link
module dpl_host import dpl_pkg::*; #(
	parameter int AW = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	dpl_if.host link,
	input wire logic [AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	dpl_host_state_t st_ff;
	logic [15:0] param_ff [`DPL_PARAM_WORDS];
	logic [AW-1:0] awa_ff;
	logic [31:0] wd_ff;
	logic [3:0] ws_ff;
	logic aw_ff;
	logic w_ff;
	logic do_wr;
	logic start;
	logic [7:0] scnt_ff;
	logic sent_ff;
	logic done_ff;
	logic abort_ff;
	logic mism_ff;
	logic [7:0] err_ff;
	logic [7:0] cond_ff;
	logic cmd_wr_ff;
	logic [7:0] cmd_ff;
	logic dat_wr_ff;
	logic [15:0] dat_ff;
	logic [AW-1:0] pidx;
	logic dev_bsy;

	// ------------------------------------------------------------
	// AXI4-Lite write side
	// ------------------------------------------------------------
	// address and data taken in either order; response after both
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_ff <= 1'b0;
			w_ff <= 1'b0;
			awa_ff <= '0;
			wd_ff <= 32'h0000_0000;
			ws_ff <= 4'h0;
		end else if (do_wr) begin
			aw_ff <= 1'b0;
			w_ff <= 1'b0;
		end else begin
			// only a real handshake fills a slot, else a beat is taken twice
			if (s_axi_awvalid && s_axi_awready) begin
				aw_ff <= 1'b1;
				awa_ff <= s_axi_awaddr;
			end
			// strobes kept with the data: the master may move them later
			if (s_axi_wvalid && s_axi_wready) begin
				w_ff <= 1'b1;
				wd_ff <= s_axi_wdata;
				ws_ff <= s_axi_wstrb;
			end
		end
	end

	assign do_wr = aw_ff && w_ff && !s_axi_bvalid;
	assign pidx = (awa_ff - `DPL_PARAM_OFS) >> 2;
	// a start while the link is busy is dropped, not queued
	assign start = do_wr && awa_ff == `DPL_CTRL_OFS && ws_ff[0] &&
		st_ff == DPL_H_IDLE;
	assign dev_bsy = link.cond_flags[`DPL_COND_BUSY_BIT];

	// write response; unmapped addresses answer SLVERR
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `DPL_RESP_OKAY;
		end else if (do_wr) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (awa_ff == `DPL_CTRL_OFS ||
				(awa_ff >= `DPL_PARAM_OFS &&
				pidx < AW'(`DPL_PARAM_WORDS))) ?
				`DPL_RESP_OKAY : `DPL_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ready stays high while the channel slot is free
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_awready <= !aw_ff && !(s_axi_awvalid && s_axi_awready);
			s_axi_wready <= !w_ff && !(s_axi_wvalid && s_axi_wready);
		end
	end

	// parameter words 0..17; the rest of the sector goes out as zero
	for (genvar i = 0; i < `DPL_PARAM_WORDS; i++) begin : g_param
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				param_ff[i] <= 16'h0000;
			end else if (do_wr && awa_ff >= `DPL_PARAM_OFS &&
				pidx == AW'(i)) begin
				if (ws_ff[0]) param_ff[i][7:0] <= wd_ff[7:0];
				if (ws_ff[1]) param_ff[i][15:8] <= wd_ff[15:8];
			end
		end
	end

	// ------------------------------------------------------------
	// AXI4-Lite read side
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `DPL_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `DPL_RESP_OKAY;
			if (s_axi_araddr == `DPL_STAT_OFS) begin
				s_axi_rdata <= {8'h00, cond_ff, err_ff, 4'h0, mism_ff,
					abort_ff, done_ff, st_ff != DPL_H_IDLE};
			end else if (s_axi_araddr == `DPL_CTRL_OFS) begin
				s_axi_rdata <= {24'h00_0000, cmd_ff};
			end else begin
				s_axi_rdata <= 32'h0000_0000;
				s_axi_rresp <= `DPL_RESP_SLVERR;
			end
		end else if (s_axi_rvalid) begin
			if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end else begin
			s_axi_arready <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// link sequencer
	// ------------------------------------------------------------
	// command strobe, wait for data request, one sector, wait idle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_ff <= DPL_H_IDLE;
			cmd_wr_ff <= 1'b0;
			cmd_ff <= 8'h00;
			dat_wr_ff <= 1'b0;
			dat_ff <= 16'h0000;
			scnt_ff <= 8'h00;
		end else begin
			unique case (st_ff)
				DPL_H_IDLE: begin
					if (start) begin
						st_ff <= DPL_H_CMD;
						cmd_wr_ff <= 1'b1;
						cmd_ff <= wd_ff[7:0];
					end
				end
				DPL_H_CMD: begin
					cmd_wr_ff <= 1'b0;
					st_ff <= DPL_H_WAIT;
				end
				DPL_H_WAIT: begin
					scnt_ff <= 8'h00;
					if (link.cond_flags[`DPL_COND_DRQ_BIT]) begin
						st_ff <= DPL_H_SEND;
					end else if (!dev_bsy) begin
						st_ff <= DPL_H_IDLE;
					end
				end
				DPL_H_SEND: begin
					dat_wr_ff <= 1'b1;
					dat_ff <= scnt_ff < 8'(`DPL_PARAM_WORDS) ?
						param_ff[scnt_ff[4:0]] : 16'h0000;
					scnt_ff <= scnt_ff + 8'h01;
					if (scnt_ff == `DPL_SECTOR_LAST) begin
						st_ff <= DPL_H_END;
					end
				end
				DPL_H_END: begin
					dat_wr_ff <= 1'b0;
					if (!dev_bsy) begin
						st_ff <= DPL_H_IDLE;
					end
				end
				default: st_ff <= DPL_H_IDLE;
			endcase
		end
	end

	// outcome: an abort after the sector went out is a mismatch
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sent_ff <= 1'b0;
			done_ff <= 1'b0;
			abort_ff <= 1'b0;
			mism_ff <= 1'b0;
			err_ff <= 8'h00;
			cond_ff <= 8'h00;
		end else if (start) begin
			sent_ff <= 1'b0;
			done_ff <= 1'b0;
			abort_ff <= 1'b0;
			mism_ff <= 1'b0;
		end else if (st_ff == DPL_H_SEND) begin
			sent_ff <= 1'b1;
		end else if ((st_ff == DPL_H_WAIT || st_ff == DPL_H_END) &&
			!dev_bsy && !link.cond_flags[`DPL_COND_DRQ_BIT]) begin
			done_ff <= 1'b1;
			err_ff <= link.err_flags;
			cond_ff <= link.cond_flags;
			abort_ff <= link.err_flags[`DPL_ERR_ABORT_BIT];
			mism_ff <= link.err_flags[`DPL_ERR_ABORT_BIT] && sent_ff;
		end
	end

	assign link.cmd_wr = cmd_wr_ff;
	assign link.cmd_code = cmd_ff;
	assign link.dat_wr = dat_wr_ff;
	assign link.dat_word = dat_ff;
endmodule : dpl_host

// ===== verilog/dpl_map.svh
`ifndef DPL_MAP_SVH
`define DPL_MAP_SVH

// ----------------------------------------------------------------
// command codes and parameter sector layout
// ----------------------------------------------------------------
`define DPL_OP_SET_PW 8'hF1
`define DPL_OP_UNLOCK 8'hF2
`define DPL_SECTOR_LAST 8'hFF
`define DPL_ID_BIT 0
`define DPL_LEVEL_BIT 8
`define DPL_PW_FIRST 8'h01
`define DPL_PW_LAST 8'h10
`define DPL_REV_WORD 8'h11
`define DPL_REV_NONE 16'h0000
`define DPL_REV_ALL 16'hFFFF
`define DPL_ATTEMPTS_INIT 3'h5

// ----------------------------------------------------------------
// device error and condition flag positions
// ----------------------------------------------------------------
`define DPL_ERR_ABORT_BIT 2
`define DPL_COND_BUSY_BIT 7
`define DPL_COND_READY_BIT 6
`define DPL_COND_DRQ_BIT 3
`define DPL_COND_ERR_BIT 0

// ----------------------------------------------------------------
// controller register map (byte addresses)
// ----------------------------------------------------------------
`define DPL_CTRL_OFS 8'h00
`define DPL_STAT_OFS 8'h04
`define DPL_PARAM_OFS 8'h40
`define DPL_PARAM_WORDS 18
`define DPL_STAT_BUSY_BIT 0
`define DPL_STAT_DONE_BIT 1
`define DPL_STAT_ABORT_BIT 2
`define DPL_STAT_MISMATCH_BIT 3
`define DPL_RESP_OKAY 2'b00
`define DPL_RESP_SLVERR 2'b10

`endif

// ===== verilog/dpl_pkg.sv
package dpl_pkg;

	// ------------------------------------------------------------
	// device command sequencer states
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		DPL_D_IDLE = 2'b00,
		DPL_D_XFER = 2'b01,
		DPL_D_EXEC = 2'b10,
		DPL_D_DONE = 2'b11
	} dpl_dev_state_t;

	// ------------------------------------------------------------
	// controller link sequencer states
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		DPL_H_IDLE = 3'b000,
		DPL_H_CMD = 3'b001,
		DPL_H_WAIT = 3'b010,
		DPL_H_SEND = 3'b011,
		DPL_H_END = 3'b100
	} dpl_host_state_t;

endpackage : dpl_pkg

// ===== verilog/dpl_if.sv
`timescale 1ns/1ps
// task-file link between controller and drive
interface dpl_if;
	logic cmd_wr;
	logic [7:0] cmd_code;
	logic dat_wr;
	logic [15:0] dat_word;
	logic [7:0] err_flags;
	logic [7:0] cond_flags;

	modport host (
		output cmd_wr,
		output cmd_code,
		output dat_wr,
		output dat_word,
		input err_flags,
		input cond_flags
	);

	modport dev (
		input cmd_wr,
		input cmd_code,
		input dat_wr,
		input dat_word,
		output err_flags,
		output cond_flags
	);
endinterface : dpl_if

// ===== verilog/dpl_pw_cmp.sv
`timescale 1ns/1ps
// full-width password compare, one word slice per generate step
module dpl_pw_cmp #(
	parameter int WORDS = 16
) (
	input wire logic [WORDS*16-1:0] given,
	input wire logic [WORDS*16-1:0] stored,
	output logic equal
);
	logic [WORDS-1:0] word_eq;

	// no byte is skipped: every slice must match
	for (genvar i = 0; i < WORDS; i++) begin : g_word
		assign word_eq[i] = given[i*16 +: 16] == stored[i*16 +: 16];
	end

	assign equal = &word_eq;
endmodule : dpl_pw_cmp

// ===== verilog/dpl_device.sv
`timescale 1ns/1ps
`include "dpl_map.svh"
// drive-side security command engine
module dpl_device import dpl_pkg::*; #(
	parameter int PW_WORDS = 16
) (
	input wire logic aclk,
	input wire logic aresetn,
	dpl_if.dev link,
	input wire logic por_evt,
	input wire logic hard_rst_evt,
	input wire logic frozen,
	output logic locked,
	output logic lock_enabled,
	output logic level_max,
	output logic [15:0] rev_code,
	output logic [2:0] attempts
);
	dpl_dev_state_t state_ff;
	logic [7:0] op_ff;
	logic [7:0] wcnt_ff;
	logic [15:0] ctl_ff;
	logic [15:0] rev_buf_ff;
	logic [PW_WORDS*16-1:0] pw_buf_ff;
	logic [PW_WORDS*16-1:0] user_pw_ff;
	logic [PW_WORDS*16-1:0] master_pw_ff;
	logic [PW_WORDS*16-1:0] ref_pw;
	logic bsy_ff;
	logic drq_ff;
	logic abt_ff;
	logic lock_en_ff;
	logic lvl_max_ff;
	logic locked_ff;
	logic [15:0] rev_ff;
	logic [2:0] tries_ff;
	logic is_known;
	logic early_abort;
	logic is_set;
	logic id_master;
	logic refuse;
	logic pw_match;
	logic exec_abort;
	logic unlock_ok;
	logic relock;
	logic last_word;

	// ------------------------------------------------------------
	// decode and decisions
	// ------------------------------------------------------------
	// unknown opcodes, frozen state and an exhausted counter all
	// abort before any data moves, which lets the host tell them
	// apart from a mismatch
	always_comb begin
		is_known = link.cmd_code == `DPL_OP_SET_PW ||
			link.cmd_code == `DPL_OP_UNLOCK;
		early_abort = !is_known || frozen || tries_ff == 3'h0;
		is_set = op_ff == `DPL_OP_SET_PW;
		id_master = ctl_ff[`DPL_ID_BIT];
		// master at Maximum and user with lock off never compare
		refuse = id_master ? lvl_max_ff : !lock_en_ff;
		ref_pw = id_master ? master_pw_ff : user_pw_ff;
		exec_abort = !is_set && (refuse || !pw_match);
		unlock_ok = !is_set && !refuse && pw_match;
		relock = por_evt || hard_rst_evt;
		last_word = link.dat_wr && wcnt_ff == `DPL_SECTOR_LAST;
	end

	dpl_pw_cmp #(
		.WORDS(PW_WORDS)
	) u_cmp (
		.given(pw_buf_ff),
		.stored(ref_pw),
		.equal(pw_match)
	);

	// ------------------------------------------------------------
	// command sequencer
	// ------------------------------------------------------------
	// sequencer: idle, sector transfer, execute, finish
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_ff <= DPL_D_IDLE;
		end else begin
			unique case (state_ff)
				DPL_D_IDLE: begin
					if (link.cmd_wr) begin
						state_ff <= early_abort ? DPL_D_DONE : DPL_D_XFER;
					end
				end
				DPL_D_XFER: begin
					if (last_word) begin
						state_ff <= DPL_D_EXEC;
					end
				end
				DPL_D_EXEC: state_ff <= DPL_D_DONE;
				DPL_D_DONE: state_ff <= DPL_D_IDLE;
			endcase
		end
	end

	// busy from command taken until the finish state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bsy_ff <= 1'b0;
		end else if (state_ff == DPL_D_IDLE && link.cmd_wr) begin
			bsy_ff <= 1'b1;
		end else if (state_ff == DPL_D_DONE) begin
			bsy_ff <= 1'b0;
		end
	end

	// data request stands for exactly one sector
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			drq_ff <= 1'b0;
		end else if (state_ff == DPL_D_IDLE && link.cmd_wr) begin
			drq_ff <= !early_abort;
		end else if (last_word) begin
			drq_ff <= 1'b0;
		end
	end

	// abort flag cleared by the next command, set on any abort
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			abt_ff <= 1'b0;
		end else if (state_ff == DPL_D_IDLE && link.cmd_wr) begin
			abt_ff <= early_abort;
		end else if (state_ff == DPL_D_EXEC) begin
			abt_ff <= exec_abort;
		end
	end

	// opcode capture
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			op_ff <= 8'h00;
		end else if (state_ff == DPL_D_IDLE && link.cmd_wr) begin
			op_ff <= link.cmd_code;
		end
	end

	// ------------------------------------------------------------
	// parameter sector capture
	// ------------------------------------------------------------
	// word counter runs over all 256 words; reserved ones dropped
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wcnt_ff <= 8'h00;
		end else if (state_ff == DPL_D_IDLE) begin
			wcnt_ff <= 8'h00;
		end else if (state_ff == DPL_D_XFER && link.dat_wr) begin
			wcnt_ff <= wcnt_ff + 8'h01;
		end
	end

	// control word, password and revision words
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctl_ff <= 16'h0000;
			rev_buf_ff <= 16'h0000;
			pw_buf_ff <= '0;
		end else if (state_ff == DPL_D_XFER && link.dat_wr) begin
			if (wcnt_ff == 8'h00) begin
				ctl_ff <= link.dat_word;
			end
			if (wcnt_ff == `DPL_REV_WORD) begin
				rev_buf_ff <= link.dat_word;
			end
			if (wcnt_ff >= `DPL_PW_FIRST && wcnt_ff <= `DPL_PW_LAST) begin
				pw_buf_ff[(wcnt_ff - 8'h01)*16 +: 16] <= link.dat_word;
			end
		end
	end

	// ------------------------------------------------------------
	// retained security state
	// ------------------------------------------------------------
	// only aresetn (factory state) clears these; power-on and hard
	// reset events leave them intact
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			user_pw_ff <= '0;
			master_pw_ff <= '0;
			lock_en_ff <= 1'b0;
			lvl_max_ff <= 1'b0;
			rev_ff <= 16'h0000;
		end else if (state_ff == DPL_D_EXEC && is_set) begin
			if (id_master) begin
				master_pw_ff <= pw_buf_ff;
				if (rev_buf_ff != `DPL_REV_NONE &&
					rev_buf_ff != `DPL_REV_ALL) begin
					rev_ff <= rev_buf_ff;
				end
			end else begin
				user_pw_ff <= pw_buf_ff;
				lock_en_ff <= 1'b1;
				lvl_max_ff <= ctl_ff[`DPL_LEVEL_BIT];
			end
		end
	end

	// lock takes effect only at a reset event, not at the set
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			locked_ff <= 1'b0;
		end else if (relock) begin
			locked_ff <= lock_en_ff;
		end else if (state_ff == DPL_D_EXEC && unlock_ok) begin
			locked_ff <= 1'b0;
		end
	end

	// attempt counter; a reset event restores it, wins over decrement
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tries_ff <= `DPL_ATTEMPTS_INIT;
		end else if (relock) begin
			tries_ff <= `DPL_ATTEMPTS_INIT;
		end else if (state_ff == DPL_D_EXEC && exec_abort &&
			tries_ff != 3'h0) begin
			tries_ff <= tries_ff - 3'h1;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign link.err_flags = {5'h00, abt_ff, 2'h0};
	assign link.cond_flags = {bsy_ff, 1'b1, 2'h0, drq_ff, 2'h0, abt_ff};
	assign locked = locked_ff;
	assign lock_enabled = lock_en_ff;
	assign level_max = lvl_max_ff;
	assign rev_code = rev_ff;
	assign attempts = tries_ff;
endmodule : dpl_device

// ===== sim/dpl_props.sv
`timescale 1ns/1ps
// watches the task-file link between the two ends
module dpl_props (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic cmd_wr,
	input wire logic [7:0] cmd_code,
	input wire logic dat_wr,
	input wire logic [15:0] dat_word,
	input wire logic [7:0] err_flags,
	input wire logic [7:0] cond_flags
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	logic busy, drq, abort;
	logic [7:0] words_ff;

	assign busy = cond_flags[7];
	assign drq = cond_flags[3];
	assign abort = err_flags[2];

	// words taken in this sector; a new command starts the count again
	always_ff @(posedge aclk) begin
		if (!aresetn || cmd_wr)
			words_ff <= 8'h00;
		else if (dat_wr && drq)
			words_ff <= words_ff + 8'h01;
	end

	// ------------------------------------------------------------
	// properties
	// ------------------------------------------------------------
	property p_flags;
		cond_flags[6] && cond_flags[0] == abort &&
			err_flags[7:3] == 5'h00 && err_flags[1:0] == 2'b00;
	endproperty
	a_flags: assert property (p_flags)
		else $error("flag bits out of place");

	property p_take;
		cmd_wr && !busy |=> busy;
	endproperty
	a_take: assert property (p_take)
		else $error("command not taken");

	property p_odd_op;
		cmd_wr && !busy && cmd_code != 8'hF1 && cmd_code != 8'hF2
			|=> busy && !drq ##[1:3] !busy && abort;
	endproperty
	a_odd_op: assert property (p_odd_op)
		else $error("unknown opcode not refused");

	property p_drq_busy;
		drq |-> busy;
	endproperty
	a_drq_busy: assert property (p_drq_busy)
		else $error("data request without busy");

	property p_drq_hold;
		drq && !(dat_wr && words_ff == 8'hFF) |=> drq;
	endproperty
	a_drq_hold: assert property (p_drq_hold)
		else $error("data request dropped early");

	property p_sector_end;
		drq && dat_wr && words_ff == 8'hFF |=> !drq ##[1:2] !busy;
	endproperty
	a_sector_end: assert property (p_sector_end)
		else $error("sector end not honoured");

	property p_err_stand;
		!busy && !cmd_wr |=> $stable(err_flags);
	endproperty
	a_err_stand: assert property (p_err_stand)
		else $error("error flags moved while idle");

	property p_cmd_pulse;
		cmd_wr |=> !cmd_wr;
	endproperty
	a_cmd_pulse: assert property (p_cmd_pulse)
		else $error("command strobe longer than one cycle");

	property p_dat_in_drq;
		dat_wr |-> drq;
	endproperty
	a_dat_in_drq: assert property (p_dat_in_drq)
		else $error("data word sent outside data request");

	// main scenarios: mismatch, clean end, early refusal
	c_mismatch: cover property (drq && dat_wr && words_ff == 8'hFF
		##1 1'b1 ##[1:2] !busy && abort);
	c_clean: cover property (drq && dat_wr && words_ff == 8'hFF
		##1 1'b1 ##[1:2] !busy && !abort);
	c_early: cover property (cmd_wr && !busy ##1 busy && !drq);
endmodule : dpl_props

// ===== sim/drive_password_lock_engine_tb.sv
`timescale 1ns/1ps
module drive_password_lock_engine_tb import dpl_pkg::*;;
	logic aclk = 0, aresetn = 0, por_evt = 0, hard_rst_evt = 0, frozen = 0;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, locked, lock_enabled, level_max;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic [15:0] rev_code, rv, upw[16], mpw[16], pw[16];
	logic [2:0] attempts;
	logic [7:0] op;
	int n_mismatch = 0, checked = 0, n_cmd = 0, k;

	always #10 aclk = ~aclk;

	dpl_if link_if();
	dpl_host dpl_host_inst (.aclk, .aresetn, .link(link_if.host),
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready);
	dpl_device dpl_device_inst (.aclk, .aresetn, .link(link_if.dev),
		.por_evt, .hard_rst_evt, .frozen, .locked, .lock_enabled,
		.level_max, .rev_code, .attempts);
	dpl_props dpl_props_inst (.aclk, .aresetn, .cmd_wr(link_if.cmd_wr),
		.cmd_code(link_if.cmd_code), .dat_wr(link_if.dat_wr),
		.dat_word(link_if.dat_word), .err_flags(link_if.err_flags),
		.cond_flags(link_if.cond_flags));

	// counts strobes on the link so a command start is never missed
	always @(posedge aclk) if (link_if.cmd_wr === 1'b1) n_cmd++;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task give_verdict;
		$display("checked %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : give_verdict

	task chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task timeout(input string what);
		chk(what, 32'h0000_0000, 32'h0000_0001);
		give_verdict();
	endtask : timeout

	// channels are released one by one as each ready is seen
	task axi_wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		int n;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hF;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1) break;
		end
		if (n == 50) timeout("bvalid");
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : axi_wr

	task axi_rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		int n;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge aclk);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1) break;
		end
		if (n == 50) timeout("rvalid");
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : axi_rd

	// status word the controller must show once a command ends
	function automatic logic [31:0] exp_stat(input logic ab,
		input logic mm);
		return {8'h00, 7'b0100000, ab, 5'h00, ab, 2'b00, 4'h0, mm, ab,
			2'b10};
	endfunction : exp_stat

	function automatic logic [15:0] rev_next(input logic [15:0] old,
		input logic [15:0] nw);
		return (nw == 16'h0000 || nw == 16'hFFFF) ? old : nw;
	endfunction : rev_next

	// loads parameter words 0..17, starts the command, waits for done
	task run_cmd(input logic [7:0] c, input logic [15:0] ctl,
		input logic [15:0] r17, input logic ab, input logic mm);
		int i, n0;
		axi_wr(8'h40, {16'h0000, ctl}, rs);
		for (i = 1; i < 17; i++)
			axi_wr(8'(64 + 4 * i), {16'h0000, pw[i-1]}, rs);
		axi_wr(8'h84, {16'h0000, r17}, rs);
		chk("bresp", 32'(rs), 32'h0);
		n0 = n_cmd;
		axi_wr(8'h00, {24'h00_0000, c}, rs);
		chk("bresp", 32'(rs), 32'h0);
		for (i = 0; i < 20 && n_cmd == n0; i++) @(posedge aclk);
		if (i == 20) timeout("cmd_wr");
		for (i = 0; i < 300; i++) begin
			axi_rd(8'h04, rd, rs);
			if (rd[1:0] === 2'b10) break;
		end
		if (i == 300) timeout("done");
		chk("rresp", 32'(rs), 32'h0);
		chk("stat", rd, exp_stat(ab, mm));
	endtask : run_cmd

	task new_pw(output logic [15:0] p[16]);
		foreach (p[i]) p[i] = 16'($urandom);
	endtask : new_pw

	// power-on or hard reset event, one cycle long
	task evt(input bit hard);
		@(posedge aclk);
		if (hard) hard_rst_evt <= 1'b1;
		else por_evt <= 1'b1;
		@(posedge aclk);
		hard_rst_evt <= 1'b0;
		por_evt <= 1'b0;
		@(posedge aclk);
	endtask : evt

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		void'($urandom(38));
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk("attempts", 32'(attempts), 32'h5);
		chk("cond", 32'(link_if.cond_flags), 32'h40);
		axi_rd(8'h08, rd, rs);
		chk("rresp", 32'(rs), 32'h2);
		chk("rdata", rd, 32'h0);
		axi_wr(8'h0C, 32'h0, rs);
		chk("bresp", 32'(rs), 32'h2);
		new_pw(mpw);
		pw = mpw;
		rv = 16'($urandom_range(16'hFFFE, 1));
		run_cmd(8'hF1, {7'h00, 1'($urandom), 8'h01}, rv, 0, 0);
		chk("lock_en", 32'(lock_enabled), 32'h0);
		chk("level", 32'(level_max), 32'h0);
		chk("rev", 32'(rev_code), 32'(rv));
		axi_rd(8'h00, rd, rs);
		chk("ctrl", rd, 32'hF1);
		for (k = 0; k < 2; k++) begin
			run_cmd(8'hF1, 16'h0001, {16{k[0]}}, 0, 0);
			chk("rev", 32'(rev_code), 32'(rev_next(rv, {16{k[0]}})));
		end
		run_cmd(8'hF2, 16'h0000, 16'h0, 1, 1);
		new_pw(upw);
		pw = upw;
		run_cmd(8'hF1, 16'h0000, 16'h0, 0, 0);
		chk("lock_en", 32'(lock_enabled), 32'h1);
		chk("locked", 32'(locked), 32'h0);
		evt(0);
		chk("locked", 32'(locked), 32'h1);
		pw = mpw;
		run_cmd(8'hF2, 16'h0001, 16'h0, 0, 0);
		chk("locked", 32'(locked), 32'h0);
		evt(1);
		chk("locked", 32'(locked), 32'h1);
		pw = upw;
		run_cmd(8'hF2, 16'h0000, 16'h0, 0, 0);
		chk("locked", 32'(locked), 32'h0);
		new_pw(upw);
		pw = upw;
		run_cmd(8'hF1, 16'h0100, 16'h0, 0, 0);
		chk("level", 32'(level_max), 32'h1);
		pw = mpw;
		rv = 16'($urandom_range(16'hFFFE, 1));
		run_cmd(8'hF1, 16'h0001, rv, 0, 0);
		chk("lock_en", 32'(lock_enabled), 32'h1);
		chk("level", 32'(level_max), 32'h1);
		evt(0);
		run_cmd(8'hF2, 16'h0001, 16'h0, 1, 1);
		chk("locked", 32'(locked), 32'h1);
		evt(1);
		chk("attempts", 32'(attempts), 32'h5);
		for (k = 1; k < 6; k++) begin
			pw = upw;
			pw[15][15:8] = ~pw[15][15:8];
			run_cmd(8'hF2, 16'h0000, 16'h0, 1, 1);
			chk("attempts", 32'(attempts), 32'(5 - k));
		end
		pw = upw;
		run_cmd(8'hF2, 16'h0000, 16'h0, 1, 0);
		run_cmd(8'hF1, 16'h0001, 16'h0, 1, 0);
		chk("locked", 32'(locked), 32'h1);
		evt(1);
		chk("attempts", 32'(attempts), 32'h5);
		run_cmd(8'hF2, 16'h0000, 16'h0, 0, 0);
		chk("locked", 32'(locked), 32'h0);
		frozen <= 1'b1;
		run_cmd(8'hF1, 16'h0000, 16'h0, 1, 0);
		run_cmd(8'hF2, 16'h0000, 16'h0, 1, 0);
		frozen <= 1'b0;
		op = 8'($urandom);
		if (op == 8'hF1 || op == 8'hF2) op = 8'h00;
		run_cmd(op, 16'h0000, 16'h0, 1, 0);
		give_verdict();
	end
endmodule : drive_password_lock_engine_tb
